/* File: rtl/lct_defs.vh */
// Register offsets, field positions, mode codes and reset values of the logic tile.
`ifndef LCT_DEFS_VH
`define LCT_DEFS_VH

`define LCT_OFF_LUT0     8'h00
`define LCT_OFF_LUT1     8'h04
`define LCT_OFF_CFG0     8'h08
`define LCT_OFF_CFG1     8'h0c
`define LCT_OFF_STAT     8'h10

`define LCT_F_MODE       0
`define LCT_G_MODE       2
`define LCT_COMBINE      4
`define LCT_LATCH        6
`define LCT_ASYNC        7
`define LCT_INIT_X       8
`define LCT_INIT_Y       9
`define LCT_BYP_X        10
`define LCT_BYP_Y        11
`define LCT_INV_CE       12
`define LCT_INV_INIT     13
`define LCT_INV_INVERT   14
`define LCT_INV_WE       15
`define LCT_XOR_F        16
`define LCT_XOR_G        17
`define LCT_MULT_F       18
`define LCT_MULT_G       19

`define LCT_MODE_LOGIC   2'h0
`define LCT_MODE_RAM     2'h1
`define LCT_MODE_SHIFT   2'h2

`define LCT_CMB_INDEP    2'h0
`define LCT_CMB_16X2     2'h1
`define LCT_CMB_32X1     2'h2
`define LCT_CMB_DUAL     2'h3

`define LCT_LUT_RST      32'h00000000
`define LCT_CFG_RST      32'h00000000

`endif

/* File: rtl/lct_logic_tile.v */
// Configurable logic tile of two slices, configured and observed over APB.
`timescale 1ns/1ns
`include "lct_defs.vh"

module lct_logic_tile #(
  parameter ADDR_W = 8
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire [7:0]        f_addr,
  input  wire [7:0]        g_addr,
  input  wire [1:0]        bypass_x,
  input  wire [1:0]        bypass_y,
  input  wire [3:0]        ram_din,
  input  wire [1:0]        shift_in,
  input  wire [1:0]        write_en,
  input  wire [1:0]        clk_en,
  input  wire [1:0]        init_force,
  input  wire [1:0]        invert_force,
  input  wire [1:0]        carry_in,
  input  wire              six_sel,
  input  wire [3:0]        feed_in,
  input  wire [1:0]        bus_din,
  input  wire [1:0]        bus_en,
  output reg  [1:0]        x_out,
  output reg  [1:0]        y_out,
  output reg  [1:0]        x_q,
  output reg  [1:0]        y_q,
  output reg  [1:0]        carry_out,
  output reg  [1:0]        five_input_mux,
  output reg               six_input_mux,
  output reg  [3:0]        feed_out,
  output reg  [1:0]        tristate_bus_driver,
  output reg  [1:0]        tristate_bus_driver_oe
);

  wire        apb_wr;
  wire [63:0] lut_all;
  wire [63:0] cfg_all;
  wire [1:0]  x_w;
  wire [1:0]  y_w;
  wire [1:0]  qx_w;
  wire [1:0]  qy_w;
  wire [1:0]  f5_w;
  wire [1:0]  cout_w;
  reg  [31:0] next_prdata;
  reg         hit;

  // Reads one bit of a 16-bit table at a 4-bit address.
  function lut_rd;
    input [15:0] table_bits;
    input [3:0]  addr;
    begin
      lut_rd = table_bits[addr];
    end
  endfunction

  // Applies a configured polarity to a control input.
  function pol;
    input raw;
    input inv;
    begin
      pol = raw ^ inv;
    end
  endfunction

  assign apb_wr = psel && penable && pwrite && pready;

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_slice
      reg  [31:0] lut;
      reg  [31:0] cfg;
      reg         qx;
      reg         qy;
      wire [3:0]  fa;
      wire [3:0]  ga;
      wire [1:0]  fmode;
      wire [1:0]  gmode;
      wire [1:0]  cmb;
      wire        we_e;
      wire        ce_e;
      wire        initf_e;
      wire        invf_e;
      wire        f_lut;
      wire        g_lut;
      wire [3:0]  g_waddr;
      wire        f_wsel;
      wire        g_wsel;
      wire        g_din;
      wire        di_f;
      wire        di_g;
      wire        c_mid;
      wire        x_cell;
      wire        y_cell;
      wire        dx;
      wire        dy;
      wire        async_x;
      wire        async_y;

      assign fa    = f_addr[4*s+3:4*s];
      assign ga    = g_addr[4*s+3:4*s];
      assign fmode = cfg[`LCT_F_MODE+1:`LCT_F_MODE];
      assign gmode = cfg[`LCT_G_MODE+1:`LCT_G_MODE];
      assign cmb   = cfg[`LCT_COMBINE+1:`LCT_COMBINE];

      assign we_e    = pol(write_en[s], cfg[`LCT_INV_WE]);
      assign ce_e    = pol(clk_en[s], cfg[`LCT_INV_CE]);
      assign initf_e = pol(init_force[s], cfg[`LCT_INV_INIT]);
      assign invf_e  = pol(invert_force[s], cfg[`LCT_INV_INVERT]);

      assign f_lut = lut_rd(lut[15:0], fa);
      assign g_lut = lut_rd(lut[31:16], ga);

      assign g_waddr = (cmb == `LCT_CMB_INDEP) ? ga : fa;
      assign f_wsel  = (cmb == `LCT_CMB_32X1) ? ~bypass_x[s] : 1'b1;
      assign g_wsel  = (cmb == `LCT_CMB_32X1) ? bypass_x[s] : 1'b1;
      assign g_din   = (cmb == `LCT_CMB_INDEP || cmb == `LCT_CMB_16X2) ? ram_din[2*s+1] : ram_din[2*s];

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lut <= `LCT_LUT_RST;
        end else if (apb_wr && paddr == (s == 0 ? `LCT_OFF_LUT0 : `LCT_OFF_LUT1)) begin
          lut <= pwdata;
        end else begin
          if (fmode == `LCT_MODE_SHIFT && ce_e) begin
            lut[15:0] <= {lut[14:0], shift_in[s]};
          end else if (fmode == `LCT_MODE_RAM && we_e && f_wsel) begin
            lut[fa] <= ram_din[2*s];
          end
          if (gmode == `LCT_MODE_SHIFT && ce_e) begin
            lut[31:16] <= {lut[30:16], shift_in[s]};
          end else if (gmode == `LCT_MODE_RAM && we_e && g_wsel) begin
            lut[{1'b1, g_waddr}] <= g_din;
          end
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg <= `LCT_CFG_RST;
        end else if (apb_wr && paddr == (s == 0 ? `LCT_OFF_CFG0 : `LCT_OFF_CFG1)) begin
          cfg <= pwdata;
        end
      end

      // Carry mux per cell; with di held low the chain forms a wide AND.
      assign di_f   = cfg[`LCT_MULT_F] ? (fa[0] & fa[1]) : fa[0];
      assign di_g   = cfg[`LCT_MULT_G] ? (ga[0] & ga[1]) : ga[0];
      assign c_mid  = f_lut ? carry_in[s] : di_f;
      assign cout_w[s] = g_lut ? c_mid : di_g;
      assign x_cell = cfg[`LCT_XOR_F] ? (f_lut ^ carry_in[s]) : f_lut;
      assign y_cell = cfg[`LCT_XOR_G] ? (g_lut ^ c_mid) : g_lut;

      assign dx = cfg[`LCT_BYP_X] ? bypass_x[s] : x_cell;
      assign dy = cfg[`LCT_BYP_Y] ? bypass_y[s] : y_cell;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          qx <= 1'b0;
          qy <= 1'b0;
        end else if (initf_e) begin
          qx <= cfg[`LCT_INIT_X];
          qy <= cfg[`LCT_INIT_Y];
        end else if (invf_e) begin
          qx <= ~cfg[`LCT_INIT_X];
          qy <= ~cfg[`LCT_INIT_Y];
        end else if (ce_e) begin
          qx <= dx;
          qy <= dy;
        end
      end

      // Asynchronous forces and open latches show at once; otherwise the stored value.
      assign async_x = cfg[`LCT_ASYNC] && (initf_e || invf_e);
      assign async_y = async_x;
      assign qx_w[s] = async_x ? (cfg[`LCT_INIT_X] ^ ~initf_e) :
                       (cfg[`LCT_LATCH] && ce_e) ? dx : qx;
      assign qy_w[s] = async_y ? (cfg[`LCT_INIT_Y] ^ ~initf_e) :
                       (cfg[`LCT_LATCH] && ce_e) ? dy : qy;

      assign f5_w[s] = bypass_x[s] ? g_lut : f_lut;
      assign x_w[s]  = x_cell;
      assign y_w[s]  = y_cell;
      assign lut_all[32*s+31:32*s] = lut;
      assign cfg_all[32*s+31:32*s] = cfg;
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_out                  <= 2'h0;
      y_out                  <= 2'h0;
      x_q                    <= 2'h0;
      y_q                    <= 2'h0;
      carry_out              <= 2'h0;
      five_input_mux         <= 2'h0;
      six_input_mux          <= 1'b0;
      feed_out               <= 4'h0;
      tristate_bus_driver    <= 2'h0;
      tristate_bus_driver_oe <= 2'h0;
    end else begin
      x_out                  <= x_w;
      y_out                  <= y_w;
      x_q                    <= qx_w;
      y_q                    <= qy_w;
      carry_out              <= cout_w;
      five_input_mux         <= f5_w;
      six_input_mux          <= six_sel ? f5_w[1] : f5_w[0];
      feed_out               <= feed_in;
      tristate_bus_driver    <= bus_din;
      tristate_bus_driver_oe <= bus_en;
    end
  end

  always @* begin
    next_prdata = 32'h00000000;
    hit = 1'b1;
    if (paddr == `LCT_OFF_LUT0) begin
      next_prdata = lut_all[31:0];
    end else if (paddr == `LCT_OFF_LUT1) begin
      next_prdata = lut_all[63:32];
    end else if (paddr == `LCT_OFF_CFG0) begin
      next_prdata = cfg_all[31:0];
    end else if (paddr == `LCT_OFF_CFG1) begin
      next_prdata = cfg_all[63:32];
    end else if (paddr == `LCT_OFF_STAT) begin
      next_prdata = {21'h0, six_input_mux, carry_out, y_out, x_out, y_q, x_q};
    end else begin
      hit = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~hit;
      prdata  <= (pwrite || !hit) ? 32'h00000000 : next_prdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // lct_logic_tile

/* File: verification/lct_fabric_partner.sv */
// Neighbouring fabric model that keeps feedthrough, bus driver and wide mux inputs moving.
`timescale 1ns/1ns
module lct_fabric_partner (
  input  wire       pclk,
  input  wire       presetn,
  output wire [3:0] feed_in,
  output wire [1:0] bus_din,
  output wire [1:0] bus_en,
  output wire       six_sel
);
  reg [8:0] cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 9'h000;
    end else begin
      cnt <= cnt + 9'h001;
    end
  end
  assign {six_sel, bus_en, bus_din, feed_in} = cnt ^ {cnt[3:0], cnt[8:4]};
endmodule // lct_fabric_partner

/* File: verification/lct_logic_tile_test.sv */
// Self-checking bench for the logic tile over APB and its fabric ports.
`timescale 1ns/1ns
`include "lct_defs.vh"
module lct_logic_tile_test;
  localparam [31:0] lut_word = 32'h5a5ac3c3;
  localparam [15:0] shift_word = 16'h1234;
  reg         pclk, presetn, psel, penable, pwrite, er;
  reg  [7:0]  paddr, f_addr, g_addr;
  reg  [31:0] pwdata, rd;
  reg  [1:0]  bypass_x, shift_in, write_en, clk_en, init_force, invert_force, bypass_y, carry_in;
  reg  [3:0]  ram_din;
  wire [31:0] prdata;
  wire        pready, pslverr, six_sel;
  wire [1:0]  x_out, y_out, x_q, y_q, carry_out, five_input_mux, bus_din, bus_en;
  wire [3:0]  feed_in;
  integer     n_mismatch, check_count, i;

  lct_fabric_partner lct_fabric_partner_inst (.pclk(pclk), .presetn(presetn), .feed_in(feed_in),
    .bus_din(bus_din), .bus_en(bus_en), .six_sel(six_sel));
  lct_logic_tile lct_logic_tile_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .f_addr(f_addr), .g_addr(g_addr), .bypass_x(bypass_x), .bypass_y(bypass_y), .ram_din(ram_din),
    .shift_in(shift_in), .write_en(write_en), .clk_en(clk_en), .init_force(init_force),
    .invert_force(invert_force), .carry_in(carry_in), .six_sel(six_sel), .feed_in(feed_in), .bus_din(bus_din),
    .bus_en(bus_en), .x_out(x_out), .y_out(y_out), .x_q(x_q), .y_q(y_q), .carry_out(carry_out),
    .five_input_mux(five_input_mux), .six_input_mux(), .feed_out(), .tristate_bus_driver(),
    .tristate_bus_driver_oe());

  task close_out;
    begin
      $display("mismatches %0d, checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask

  task xfer(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
        @(posedge pclk);
        n = n + 1;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
        n_mismatch = n_mismatch + 1;
        close_out;
      end
    end
  endtask

  task rdchk(input [7:0] a, input [31:0] exp);
    begin
      xfer(a, 1'b0, 32'h0);
      chk(rd, exp);
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, f_addr, g_addr, bypass_x} = '0;
    {shift_in, write_en, clk_en, init_force, invert_force, ram_din, bypass_y, carry_in} = '0;
    n_mismatch = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(8'h14, 1'b1, 32'hffffffff);
    chk({31'h0, er}, 32'h1);
    rdchk(`LCT_OFF_CFG0, `LCT_CFG_RST);
    xfer(`LCT_OFF_LUT0, 1'b1, lut_word);
    rdchk(`LCT_OFF_LUT0, lut_word);
    clk_en <= 2'h1;
    for (i = 0; i < 16; i = i + 1) begin
      f_addr <= i[7:0];
      g_addr <= i[7:0];
      bypass_x <= {1'b0, i[0]};
      repeat (3) @(posedge pclk);
      chk({x_out[0], y_out[0], five_input_mux[0], x_q[0]},
          {lut_word[i], lut_word[16+i], lut_word[i[0] ? 16+i : i], lut_word[i]});
    end
    xfer(`LCT_OFF_CFG0, 1'b1, 32'h100);
    f_addr <= 8'h02;
    init_force <= 2'h1;
    repeat (3) @(posedge pclk);
    chk(x_q[0], 1'b1);
    init_force <= 2'h0;
    clk_en <= 2'h0;
    repeat (3) @(posedge pclk);
    chk(x_q[0], 1'b1);
    f_addr <= 8'h00;
    clk_en <= 2'h1;
    invert_force <= 2'h1;
    repeat (3) @(posedge pclk);
    chk(x_q[0], 1'b0);
    invert_force <= 2'h0;
    xfer(`LCT_OFF_CFG0, 1'b1, 32'h2);
    for (i = 15; i >= 0; i = i - 1) begin
      shift_in <= {1'b0, shift_word[i]};
      @(posedge pclk);
    end
    clk_en <= 2'h0;
    rdchk(`LCT_OFF_LUT0, {lut_word[31:16], shift_word});
    xfer(`LCT_OFF_CFG0, 1'b1, 32'h1);
    f_addr <= 8'h03;
    ram_din <= 4'h1;
    write_en <= 2'h1;
    @(posedge pclk);
    write_en <= 2'h0;
    repeat (3) @(posedge pclk);
    chk(x_out[0], 1'b1);
    rdchk(`LCT_OFF_LUT0, {lut_word[31:16], shift_word | 16'h0008});
    xfer(`LCT_OFF_CFG0, 1'b1, 32'h15);
    f_addr <= 8'h05;
    ram_din <= 4'h2;
    write_en <= 2'h1;
    @(posedge pclk);
    write_en <= 2'h0;
    rdchk(`LCT_OFF_LUT0, ({lut_word[31:16], shift_word | 16'h0008} | 32'h00200000) & ~32'h00000020);
    xfer(`LCT_OFF_CFG0, 1'b1, 32'h440);
    bypass_x <= 2'h1;
    clk_en <= 2'h1;
    repeat (2) @(posedge pclk);
    chk(x_q[0], 1'b1);
    clk_en <= 2'h0;
    xfer(`LCT_OFF_CFG0, 1'b1, 32'h180);
    invert_force <= 2'h1;
    repeat (2) @(posedge pclk);
    chk(x_q[0], 1'b0);
    invert_force <= 2'h0;
    xfer(`LCT_OFF_LUT0, 1'b1, 32'hffff0000);
    xfer(`LCT_OFF_CFG0, 1'b1, 32'h70800);
    f_addr <= 8'h03;
    carry_in <= 2'h1;
    bypass_y <= 2'h1;
    clk_en <= 2'h1;
    repeat (3) @(posedge pclk);
    chk({x_out[0], y_out[0], carry_out[0], y_q[0]}, 4'hb);
    f_addr <= 8'h01;
    repeat (3) @(posedge pclk);
    chk({y_out[0], carry_out[0]}, 2'h2);
    close_out;
  end
endmodule // lct_logic_tile_test

/* File: verification/lct_tile_props.sv */
// Concurrent checks on the logic tile's APB answer and fabric pass-through outputs.
`timescale 1ns/1ns
module lct_tile_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  input wire        six_sel,
  input wire [3:0]  feed_in,
  input wire [1:0]  bus_din,
  input wire [1:0]  bus_en,
  input wire [3:0]  feed_out,
  input wire [1:0]  five_input_mux,
  input wire        six_input_mux,
  input wire [1:0]  tristate_bus_driver,
  input wire [1:0]  tristate_bus_driver_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_access_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  chk_error_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  chk_error_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("read data not zero on error");
  chk_feed_path: assert property (feed_out == $past(feed_in))
    else $error("feedthrough mismatch");
  chk_bus_enable: assert property (tristate_bus_driver_oe == $past(bus_en))
    else $error("bus driver enable mismatch");
  chk_bus_data: assert property (tristate_bus_driver == $past(bus_din))
    else $error("bus driver data mismatch");
  chk_six_select: assert property (six_input_mux == ($past(six_sel) ? five_input_mux[1] : five_input_mux[0]))
    else $error("wide mux picked wrong slice");
  cover property (pready && pslverr);
  cover property (pready && !pslverr);
  cover property ($rose(six_input_mux));
endmodule // lct_tile_props

bind lct_logic_tile lct_tile_props lct_tile_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .six_sel(six_sel),
  .feed_in(feed_in), .bus_din(bus_din), .bus_en(bus_en), .feed_out(feed_out), .five_input_mux(five_input_mux),
  .six_input_mux(six_input_mux), .tristate_bus_driver(tristate_bus_driver),
  .tristate_bus_driver_oe(tristate_bus_driver_oe));
